// >>> pkg/fspc_defs.vh
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH
// ----------------------------------------
// register map (index = byte address)
// ----------------------------------------
`define FSPC_REG_CSR      4'h0
`define FSPC_REG_PTR_LO   4'h1
`define FSPC_REG_PTR_HI   4'h2
`define FSPC_REG_DATA_LO  4'h3
`define FSPC_REG_DATA_HI  4'h4
`define FSPC_REG_LOCK     4'h5
`define FSPC_REG_STAT     4'h6
// ----------------------------------------
// control/status fields
// ----------------------------------------
`define FSPC_CSR_EN       0
`define FSPC_CSR_IE       7
`define FSPC_CSR_BUSY     6
`define FSPC_CSR_REEN     4
`define FSPC_CMD_MASK     8'h7F
`define FSPC_CMD_ERASE    8'h03
`define FSPC_CMD_LOAD     8'h01
`define FSPC_CMD_WRITE    8'h05
`define FSPC_CMD_LOCK     8'h09
`define FSPC_CMD_REEN     8'h11
`define FSPC_CSR_RST      8'h00
`define FSPC_LOCK_RST     6'h3F
// ----------------------------------------
// geometry and timing
// ----------------------------------------
`define FSPC_WORD_BITS    6
`define FSPC_PAGE_WORDS   64
`define FSPC_WINDOW_CYC   3'h4
`define FSPC_CLK_KHZ      40000
`define FSPC_TPROG_US     4100
`define FSPC_APP_VECTOR   16'h0000
`endif

// >>> hdl/fspc_page_buf.v
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defs.vh"
module fspc_page_buf
(
	input  wire        core_clk,  // clock
	input  wire        rst,       // sync reset
	input  wire        clr,       // erase whole buffer
	input  wire        wr,        // load one word
	input  wire [5:0]  waddr,     // word index
	input  wire [15:0] wdata,     // word data
	input  wire [5:0]  raddr,     // read index
	output wire [15:0] rdata      // read data
);
	reg [15:0] mem_r [0:`FSPC_PAGE_WORDS-1];
	genvar i;
	generate
		for (i = 0; i < `FSPC_PAGE_WORDS; i = i + 1)
		begin : g_word
			always @(posedge core_clk)
			begin
				if (rst || clr)
					mem_r[i] <= 16'hFFFF;
				else if (wr && waddr == i)
					mem_r[i] <= wdata;
			end
		end
	endgenerate
	assign rdata = mem_r[raddr];
endmodule
`default_nettype wire

// >>> hdl/fspc_ctrl.v
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defs.vh"
module fspc_ctrl #
(
	parameter [15:0] BOOT_VECTOR = 16'h1C00,                     // boot start word
	parameter [15:0] RWW_LIMIT   = 16'h1C00,                     // first halting-section byte
	parameter [31:0] PROG_CYC    = `FSPC_TPROG_US * (`FSPC_CLK_KHZ / 1000) // op length
)
(
	input  wire        core_clk,          // 40 MHz clock
	input  wire        rst,               // sync reset, high
	input  wire [3:0]  reg_addr,          // register index
	input  wire [7:0]  reg_wdata,         // write data
	input  wire        reg_wr,            // write strobe
	input  wire        reg_rd,            // read strobe
	output reg  [7:0]  reg_rdata,         // read data, cycle after strobe
	input  wire        spm_strobe,        // store instruction executed
	input  wire        boot_reset_fuse,   // boot reset fuse, 0 programmed
	input  wire        eeprom_write_busy, // eeprom write in progress
	input  wire [5:0]  byte_rd_word,      // buffer readback index
	output reg  [7:0]  byte_rd_data,      // buffer byte, z0 selected
	output reg  [15:0] reset_vector,      // fetch address after reset
	output reg         cpu_halt,          // halts cpu
	output reg         rww_blocked,       // rww section unreadable
	output reg         irq_req,           // completion interrupt level
	output reg         flash_erase,       // erase pulse to array
	output reg         flash_write,       // write pulse to array
	output reg  [15:0] flash_page_addr,   // latched page address
	output reg  [5:0]  lock_bits          // programmed lock bits, 0 set
);
// ----------------------------------------
// state
// ----------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_ARM  = 2'h1;
	localparam ST_PROG = 2'h2;
	reg [1:0]  state_r;
	reg [1:0]  state_nxt;
	reg [7:0]  csr_r;
	reg [7:0]  ptr_lo_r;
	reg [7:0]  ptr_hi_r;
	reg [7:0]  dat_lo_r;
	reg [7:0]  dat_hi_r;
	reg [2:0]  win_r;
	reg [31:0] prog_cnt_r;
	reg [7:0]  op_r;
	reg        op_halt_r;
	reg        rww_busy_flag_r;
	reg        loading_r;
	reg [5:0]  lock_r;
	wire [15:0] ptr = {ptr_hi_r, ptr_lo_r};
	wire [7:0]  cmd = csr_r & `FSPC_CMD_MASK;
	wire [5:0]  word_in_page_field = ptr[`FSPC_WORD_BITS:1];
	wire [15:0] page_addr_field = {ptr[15:`FSPC_WORD_BITS+1], 7'h00};
	wire        go = (state_r == ST_ARM) && spm_strobe;
	wire        csr_wr = reg_wr && reg_addr == `FSPC_REG_CSR;
	wire        buf_wr = go && cmd == `FSPC_CMD_LOAD && !eeprom_write_busy;
	wire        buf_clr = (state_r == ST_PROG && op_r == `FSPC_CMD_WRITE && prog_cnt_r == 32'h1)
		|| (go && cmd == `FSPC_CMD_REEN) || (eeprom_write_busy && loading_r);
// ----------------------------------------
// command decode
// ----------------------------------------
	wire        cmd_reen = cmd == `FSPC_CMD_REEN;
	wire        arm_take = (state_r == ST_ARM) && (state_nxt == ST_PROG);
// ----------------------------------------
// pointer and data word
// ----------------------------------------
	// software may rewrite these during an operation; the page is latched apart
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			ptr_lo_r <= 8'h00;
			ptr_hi_r <= 8'h00;
			dat_lo_r <= 8'h00;
			dat_hi_r <= 8'h00;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`FSPC_REG_PTR_LO:  ptr_lo_r <= reg_wdata;
				`FSPC_REG_PTR_HI:  ptr_hi_r <= reg_wdata;
				`FSPC_REG_DATA_LO: dat_lo_r <= reg_wdata;
				`FSPC_REG_DATA_HI: dat_hi_r <= reg_wdata;
				default:           ;
			endcase
		end
	end
// ----------------------------------------
// status flags
// ----------------------------------------
	// a start and a re-enable carry different commands, so they never meet
	always @(posedge core_clk)
	begin
		if (rst)
			rww_busy_flag_r <= 1'b0;
		else if (arm_take && cmd != `FSPC_CMD_LOCK)
			rww_busy_flag_r <= 1'b1;
		else if (go && cmd_reen)
			rww_busy_flag_r <= 1'b0;
	end
	// clear wins over a load in the same cycle
	always @(posedge core_clk)
	begin
		if (rst || buf_clr)
			loading_r <= 1'b0;
		else if (buf_wr)
			loading_r <= 1'b1;
	end
// ----------------------------------------
// store window
// ----------------------------------------
	// counts cycles since the control write; the fourth one still takes a store
	always @(posedge core_clk)
	begin
		if (rst || state_r != ST_ARM)
			win_r <= 3'h1;
		else
			win_r <= win_r + 3'h1;
	end
// ----------------------------------------
// lock bits
// ----------------------------------------
	// a zero data bit programs its lock bit; a one leaves it as it is
	always @(posedge core_clk)
	begin
		if (rst)
			lock_r <= `FSPC_LOCK_RST;
		else if (state_r == ST_PROG && prog_cnt_r == 32'h1 && op_r == `FSPC_CMD_LOCK)
			lock_r <= lock_r & dat_lo_r[5:0];
	end
	wire [15:0] buf_rdata;
	fspc_page_buf u_buf
	(
		.core_clk (core_clk),
		.rst      (rst),
		.clr      (buf_clr),
		.wr       (buf_wr),
		.waddr    (word_in_page_field),
		.wdata    ({dat_hi_r, dat_lo_r}),
		.raddr    (byte_rd_word),
		.rdata    (buf_rdata)
	);
// ----------------------------------------
// sequencer
// ----------------------------------------
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (csr_wr && reg_wdata[`FSPC_CSR_EN] && !eeprom_write_busy)
				state_nxt = ST_ARM;
			ST_ARM:
			begin
				if (go && (cmd == `FSPC_CMD_ERASE || cmd == `FSPC_CMD_WRITE
					|| cmd == `FSPC_CMD_LOCK))
					state_nxt = ST_PROG;
				else if (go || win_r == `FSPC_WINDOW_CYC)
					state_nxt = ST_IDLE;
			end
			ST_PROG: if (prog_cnt_r == 32'h1)
				state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			state_r         <= ST_IDLE;
			csr_r           <= `FSPC_CSR_RST;
			prog_cnt_r      <= 32'h0;
			op_r            <= 8'h00;
			op_halt_r       <= 1'b0;
			flash_erase     <= 1'b0;
			flash_write     <= 1'b0;
			flash_page_addr <= 16'h0000;
		end
		else
		begin
			state_r     <= state_nxt;
			flash_erase <= 1'b0;
			flash_write <= 1'b0;
			// busy bit is read-only; control writes only while idle
			if (csr_wr && state_r == ST_IDLE && !eeprom_write_busy)
				csr_r <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
			if (state_r == ST_ARM && state_nxt == ST_IDLE)
				csr_r[5:0] <= 6'h00;
			if (state_r == ST_ARM && state_nxt == ST_PROG)
			begin
				op_r       <= cmd;
				prog_cnt_r <= PROG_CYC;
				if (cmd != `FSPC_CMD_LOCK)
				begin
					flash_page_addr <= page_addr_field;
					op_halt_r       <= page_addr_field >= RWW_LIMIT;
				end
			end
			if (state_r == ST_PROG)
			begin
				prog_cnt_r <= prog_cnt_r - 32'h1;
				if (prog_cnt_r == 32'h1)
				begin
					csr_r[5:0] <= 6'h00;
					op_halt_r  <= 1'b0;
					flash_erase <= op_r == `FSPC_CMD_ERASE;
					flash_write <= op_r == `FSPC_CMD_WRITE;
				end
			end
		end
	end
// ----------------------------------------
// outputs
// ----------------------------------------
	// fuse is sampled only, never written back; it is followed in reset as well
	always @(posedge core_clk)
		reset_vector <= boot_reset_fuse ? `FSPC_APP_VECTOR : BOOT_VECTOR;
	always @(posedge core_clk)
	begin
		if (rst)
			byte_rd_data <= 8'h00;
		else
			byte_rd_data <= ptr[0] ? buf_rdata[15:8] : buf_rdata[7:0];
	end
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			cpu_halt    <= 1'b0;
			rww_blocked <= 1'b0;
		end
		else
		begin
			cpu_halt    <= op_halt_r;
			rww_blocked <= rww_busy_flag_r;
		end
	end
	always @(posedge core_clk)
	begin
		if (rst)
			irq_req <= 1'b0;
		else
			irq_req <= csr_r[`FSPC_CSR_IE] && !csr_r[`FSPC_CSR_EN];
	end
	always @(posedge core_clk)
	begin
		if (rst)
			lock_bits <= `FSPC_LOCK_RST;
		else
			lock_bits <= lock_r;
	end
// ----------------------------------------
// register readback
// ----------------------------------------
	// data stand for one cycle only, zero otherwise
	always @(posedge core_clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else
		begin
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				case (reg_addr)
					`FSPC_REG_CSR:     reg_rdata <= {csr_r[7], rww_busy_flag_r, csr_r[5:0]};
					`FSPC_REG_PTR_LO:  reg_rdata <= ptr_lo_r;
					`FSPC_REG_PTR_HI:  reg_rdata <= ptr_hi_r;
					`FSPC_REG_DATA_LO: reg_rdata <= dat_lo_r;
					`FSPC_REG_DATA_HI: reg_rdata <= dat_hi_r;
					`FSPC_REG_LOCK:    reg_rdata <= eeprom_write_busy ? 8'h00 : {2'h3, lock_r};
					`FSPC_REG_STAT:    reg_rdata <= {6'h00, loading_r, state_r == ST_PROG};
					default:           reg_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> testbench/fspc_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------
// port checker
// ----------
module fspc_chk #
(
	parameter [15:0] BOOT_VECTOR = 16'h1C00
)
(
	input wire        core_clk,        // clock
	input wire        rst,             // sync reset
	input wire        reg_rd,          // read strobe
	input wire [7:0]  reg_rdata,       // read data
	input wire        spm_strobe,      // store strobe
	input wire        boot_reset_fuse, // boot fuse
	input wire [15:0] reset_vector,    // reset vector
	input wire        cpu_halt,        // cpu halt
	input wire        rww_blocked,     // rww blocked
	input wire        flash_erase,     // erase pulse
	input wire        flash_write,     // write pulse
	input wire [15:0] flash_page_addr, // latched page
	input wire [5:0]  lock_bits        // lock bits
);
	// strobes seen in the last four cycles; latencies are allowed some slack
	reg [3:0] sh_r;
	always @(posedge core_clk)
		sh_r <= rst ? 4'h0 : {sh_r[2:0], spm_strobe};
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_vec;
		reset_vector == ($past(boot_reset_fuse) ? 16'h0000 : BOOT_VECTOR);
	endproperty
	a_vec: assert property (p_vec) else $error("reset vector wrong");
	property p_pe;
		flash_erase |=> !flash_erase;
	endproperty
	a_pe: assert property (p_pe) else $error("erase pulse too long");
	property p_pw;
		flash_write |=> !flash_write && !flash_erase;
	endproperty
	a_pw: assert property (p_pw) else $error("write pulse too long");
	property p_op;
		flash_erase || flash_write |-> rww_blocked;
	endproperty
	a_op: assert property (p_op) else $error("op end while unblocked");
	property p_halt;
		cpu_halt |-> rww_blocked;
	endproperty
	a_halt: assert property (p_halt) else $error("halt without block");
	property p_rise;
		$rose(rww_blocked) || $rose(cpu_halt) |-> |sh_r;
	endproperty
	a_rise: assert property (p_rise) else $error("block without store");
	property p_fell;
		$fell(rww_blocked) |-> |sh_r;
	endproperty
	a_fell: assert property (p_fell) else $error("block dropped alone");
	property p_addr;
		$changed(flash_page_addr) |-> |sh_r;
	endproperty
	a_addr: assert property (p_addr) else $error("page moved mid op");
	property p_lock;
		$changed(lock_bits) |-> !cpu_halt && (lock_bits & ~$past(lock_bits)) == 6'h00;
	endproperty
	a_lock: assert property (p_lock) else $error("lock bit restored");
	property p_rd;
		!$past(reg_rd) |-> reg_rdata == 8'h00;
	endproperty
	a_rd: assert property (p_rd) else $error("read data outside slot");
	c_wr: cover property (flash_write);
	c_er: cover property (flash_erase);
	c_lk: cover property ($changed(lock_bits));
endmodule
bind fspc_ctrl fspc_chk #(.BOOT_VECTOR(BOOT_VECTOR)) i_chk (.core_clk, .rst, .reg_rd,
	.reg_rdata, .spm_strobe, .boot_reset_fuse, .reset_vector, .cpu_halt, .rww_blocked,
	.flash_erase, .flash_write, .flash_page_addr, .lock_bits);
`default_nettype wire

// >>> testbench/fspc_cpu.sv
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defs.vh"
// ----------
// boot loader core model
// ----------
module fspc_cpu
(
	input  wire        core_clk,  // clock
	input  wire [7:0]  reg_rdata, // read data
	output logic [3:0] reg_addr,  // register index
	output logic [7:0] reg_wdata, // write data
	output logic       reg_wr,    // write strobe
	output logic       reg_rd,    // read strobe
	output logic       spm_strobe // store instruction
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd, spm_strobe} = 15'h0000;
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task stb(input int gap);
		repeat (gap) @(posedge core_clk);
		spm_strobe <= 1'b1;
		@(posedge core_clk);
		spm_strobe <= 1'b0;
	endtask
	// gap 0..3 keeps the store inside the four-cycle window
	task spm(input logic [7:0] c, input int gap);
		wr(`FSPC_REG_CSR, c);
		stb(gap);
	endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defs.vh"
module tb;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic fuse = 1'b1;
	logic ee = 1'b0;
	logic [5:0] brw = 6'h00;
	wire [3:0] a;
	wire [7:0] wd, rd, bd;
	wire wr, rs, stb, halt, blk, irq, fer, fwr;
	wire [15:0] vec, pg;
	wire [5:0] lk;
	int fails, checks_done, cycles, n_er, n_wr;
	// counts of end-of-operation pulses seen on the array strobes
	always @(posedge core_clk)
	begin
		n_er <= n_er + fer;
		n_wr <= n_wr + fwr;
	end
	fspc_cpu u_cpu (.core_clk, .reg_rdata(rd), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
		.reg_rd(rs), .spm_strobe(stb));
	fspc_ctrl #(.BOOT_VECTOR(16'h1C00), .RWW_LIMIT(16'h1C00), .PROG_CYC(20)) i_fspc_ctrl
		(.core_clk, .rst, .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rs),
		.reg_rdata(rd), .spm_strobe(stb), .boot_reset_fuse(fuse), .eeprom_write_busy(ee),
		.byte_rd_word(brw), .byte_rd_data(bd), .reset_vector(vec), .cpu_halt(halt),
		.rww_blocked(blk), .irq_req(irq), .flash_erase(fer), .flash_write(fwr),
		.flash_page_addr(pg), .lock_bits(lk));
	initial
		forever #12.5 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			conclude;
		end
	end
	task conclude;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task ptr(input logic [15:0] p);
		u_cpu.wr(`FSPC_REG_PTR_LO, p[7:0]);
		u_cpu.wr(`FSPC_REG_PTR_HI, p[15:8]);
	endtask
	task op(input logic [7:0] c, input logic [15:0] p, input int g);
		ptr(p);
		u_cpu.spm(c, g);
	endtask
	task ld(input logic [15:0] p, input logic [15:0] d);
		u_cpu.wr(`FSPC_REG_DATA_LO, d[7:0]);
		u_cpu.wr(`FSPC_REG_DATA_HI, d[15:8]);
		op(8'h01, p, 1);
	endtask
	task wait_en;
		logic [7:0] d;
		d = 8'h01;
		repeat (40)
			if (d[0])
				u_cpu.rd(`FSPC_REG_CSR, d);
		chk("en", d[0], 16'h0000);
	endtask
	task reen;
		u_cpu.spm(8'h11, 0);
		cyc(3);
		chk("blk", blk, 16'h0000);
	endtask
	task t_rst;
		chk("vec", vec, 16'h0000);
		chk("lock", lk, 16'h003F);
		fuse <= 1'b0;
		cyc(2);
		chk("vec", vec, 16'h1C00);
		fuse <= 1'b1;
		cyc(2);
		chk("vec", vec, 16'h0000);
	endtask
	task t_wr;
		op(8'h03, 16'h0180, 0);
		cyc(4);
		chk("blk", {halt, blk}, 16'h0001);
		wait_en;
		chk("ner", n_er[15:0], 16'h0001);
		reen;
		ld(16'h018A, 16'hA55A);
		ld(16'h0184, 16'h1234);
		brw <= 6'h05;
		cyc(2);
		chk("blo", bd, 16'h005A);
		u_cpu.wr(`FSPC_REG_PTR_LO, 8'h85);
		cyc(2);
		chk("bhi", bd, 16'h00A5);
		op(8'h05, 16'h0180, 3);
		cyc(4);
		chk("blk", {halt, blk}, 16'h0001);
		wait_en;
		chk("pg", pg, 16'h0180);
		chk("nwr", {n_er[7:0], n_wr[7:0]}, 16'h0101);
		chk("buf", bd, 16'h00FF);
		reen;
	endtask
	task t_er;
		op(8'h03, 16'h1C80, 0);
		cyc(4);
		chk("halt", halt, 16'h0001);
		ptr(16'h0000);
		wait_en;
		chk("pg", pg, 16'h1C80);
		chk("halt", halt, 16'h0000);
		reen;
	endtask
	task t_lock;
		logic [7:0] d;
		ptr(16'h0001);
		u_cpu.wr(`FSPC_REG_DATA_LO, 8'hF5);
		u_cpu.spm(8'h89, 2);
		cyc(4);
		chk("blk", {irq, halt, blk}, 16'h0000);
		u_cpu.rd(`FSPC_REG_CSR, d);
		chk("csr", d, 16'h0089);
		wait_en;
		cyc(2);
		chk("lock", lk, 16'h0035);
		u_cpu.rd(`FSPC_REG_LOCK, d);
		chk("lockrd", d, 16'h00F5);
		chk("irq", irq, 16'h0001);
		u_cpu.wr(`FSPC_REG_CSR, 8'h00);
		cyc(2);
		chk("irq", irq, 16'h0000);
	endtask
	task t_late;
		logic [7:0] d;
		u_cpu.wr(`FSPC_REG_CSR, 8'h03);
		cyc(6);
		u_cpu.rd(`FSPC_REG_CSR, d);
		chk("csr", d, 16'h0000);
		u_cpu.stb(0);
		cyc(4);
		chk("blk", blk, 16'h0000);
	endtask
	task t_ee;
		logic [7:0] d;
		ld(16'h0182, 16'h1234);
		ee <= 1'b1;
		op(8'h03, 16'h0180, 0);
		cyc(4);
		chk("blk", blk, 16'h0000);
		brw <= 6'h01;
		cyc(2);
		chk("buf", bd, 16'h00FF);
		u_cpu.rd(`FSPC_REG_LOCK, d);
		chk("lockrd", d, 16'h0000);
		ee <= 1'b0;
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		cyc(1);
		t_rst;
		t_wr;
		t_er;
		t_lock;
		t_late;
		t_ee;
		conclude;
	end
endmodule
`default_nettype wire
